//--- logic/mlox_pkg.sv
// package for the multiply, load and logic execution group
// assumes a 16-bit instruction word and a 144-word data memory
package mlox_pkg;
    localparam int unsigned DWIDTH = 16;
    localparam int unsigned AWIDTH = 8;
    localparam int unsigned ACCW = 32;
    localparam int unsigned MEM_WORDS = 144;
    localparam logic [7:0] ADDR_LAST = 8'h8f;
    localparam int unsigned MODE_BIT = 7;
    localparam int unsigned IMM_W = 13;
    // opcode patterns, bits 15..8 with bit 7 as addressing mode; multiply-immediate is bits 15..13, no-op all 16 bits
    localparam logic [7:0] OP_LMA = 8'h6c;
    localparam logic [7:0] OP_LMA_MOVE = 8'h6b;
    localparam logic [7:0] OP_MODAUX = 8'h68;
    localparam logic [7:0] OP_MULMEM = 8'h6d;
    localparam logic [7:0] OP_ORACC = 8'h7a;
    localparam logic [2:0] OP_MULIMM = 3'h4;
    localparam logic [15:0] OP_NOOP = 16'h7f80;
    // indirect field: bit 5 increment, bit 4 decrement, bit 3 keep pointer, bit 0 new pointer
    localparam int unsigned IND_INC = 5;
    localparam int unsigned IND_DEC = 4;
    localparam int unsigned IND_KEEP = 3;
    localparam int unsigned IND_NEWP = 0;
    localparam logic [ACCW-1:0] ACC_RST = 32'h0000_0000;
    localparam logic [ACCW-1:0] PROD_RST = 32'h0000_0000;
    localparam logic [DWIDTH-1:0] WORD_RST = 16'h0000;
    // most negative operand and the uncorrected product that it gives when squared
    localparam logic [DWIDTH-1:0] MIN_WORD = 16'h8000;
    localparam logic [ACCW-1:0] MIN_SQUARE = 32'hc000_0000;

    typedef enum logic [2:0] {
        MLOX_OTHER = 3'b000,
        MLOX_LMA = 3'b001,
        MLOX_LMA_MOVE = 3'b010,
        MLOX_MODAUX = 3'b011,
        MLOX_MULMEM = 3'b100,
        MLOX_MULIMM = 3'b101,
        MLOX_ORACC = 3'b110,
        MLOX_NOOP = 3'b111
    } mlox_op_t;

    typedef struct packed {
        logic [ACCW-1:0] acc;
        logic [ACCW-1:0] prod;
        logic [DWIDTH-1:0] mcand;
        logic [DWIDTH-1:0] aux0;
        logic [DWIDTH-1:0] aux1;
        logic aux_sel;
        logic page;
    } mlox_state_t;
endpackage : mlox_pkg

//--- logic/mlox_exec.sv
// execution unit for the load-multiplicand, modify-auxiliary, multiply, no-op and or group
// assumes one instruction is presented per enabled cycle; memory is internal flip-flops
// the data page bit and preload port are driven by logic outside this group
// limitation: no saturation anywhere, sums and products wrap at 32 bits
`timescale 1ns/1ps

// How it works
// RL1 - load multiplicand, then accumulate product
// RL2 - same, plus copy word upward one
// RL3 - indirect modify steps aux, reloads pointer
// RL4 - direct modify-auxiliary does nothing
// RL5 - modify without step, pointer zero equals load
// RL6 - signed multiplicand times memory word to product
// RL7 - most negative squared gives c0000000 uncorrected
// RL8 - no interrupt entry right after multiply
// RL9 - software consumes product after each multiply
// RL10 - multiply by signed 13-bit immediate
// RL11 - no-op changes nothing, one cycle
// RL12 - or word into accumulator low half
// RL13 - page bit selects direct data page
// RL14 - pointer picks aux register for address
// RL15 - bit seven selects direct or indirect
// RL16 - accumulator and product 32 bits wide
module mlox_exec (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // instruction issue
    input wire logic instr_valid,
    input wire logic [mlox_pkg::DWIDTH-1:0] instr,
    input wire logic irq_pending,
    // memory preload port, used by software loaders
    input wire logic mem_wr_en,
    input wire logic [mlox_pkg::AWIDTH-1:0] mem_wr_addr,
    input wire logic [mlox_pkg::DWIDTH-1:0] mem_wr_data,
    input wire logic page_wr_en,
    input wire logic page_wr_val,
    // state view
    output mlox_pkg::mlox_state_t state,
    output logic irq_take,
    output logic instr_done,
    output logic [mlox_pkg::DWIDTH-1:0] mem_rd_data,
    input wire logic [mlox_pkg::AWIDTH-1:0] mem_rd_addr
);
    import mlox_pkg::*;

    // storage and architectural registers
    logic [DWIDTH-1:0] mem_r [MEM_WORDS];
    logic [ACCW-1:0] acc_r;
    logic [ACCW-1:0] prod_r;
    logic [DWIDTH-1:0] mcand_r;
    logic [DWIDTH-1:0] aux_r [2];
    logic aux_sel_r;
    logic page_r;
    logic irq_block_r;
    logic done_r;
    logic [DWIDTH-1:0] rd_r;

    // decode and operand path
    mlox_op_t op;
    logic indirect;
    logic [AWIDTH-1:0] addr;
    logic [AWIDTH-1:0] addr_up;
    logic addr_ok;
    logic up_ok;
    logic [DWIDTH-1:0] word;
    logic [DWIDTH-1:0] mul_b;
    logic go;

    // per-instruction strobes
    logic in_group;
    logic lma_any;
    logic mul_any;
    logic shadow_set;
    logic aux_walk;
    logic aux_inc;
    logic aux_dec;
    logic ptr_load;
    logic move_en;
    logic preload_en;
    logic [DWIDTH-1:0] aux_cur;
    logic [ACCW-1:0] or_word;

    // multiplier
    logic [ACCW-1:0] mcand_ext;
    logic [ACCW-1:0] mulb_ext;
    logic [ACCW-1:0] prod_raw;
    logic both_min;
    logic [ACCW-1:0] prod_nxt;

    assign go = ce && instr_valid;
    assign indirect = instr[MODE_BIT]; // RL15

    // decode
    // multiply-immediate owns the whole top-three-bit space, so it is tested first
    always_comb begin
        op = MLOX_OTHER;
        if (instr[15:13] == OP_MULIMM) begin
            op = MLOX_MULIMM; // RL10
        end else if (instr == OP_NOOP) begin
            op = MLOX_NOOP; // RL11
        end else begin
            unique case (instr[15:8])
                OP_LMA: op = MLOX_LMA;
                OP_LMA_MOVE: op = MLOX_LMA_MOVE;
                OP_MODAUX: op = MLOX_MODAUX;
                OP_MULMEM: op = MLOX_MULMEM;
                OP_ORACC: op = MLOX_ORACC;
                default: op = MLOX_OTHER;
            endcase
        end
    end

    // group strobes shared by the register processes below
    assign in_group = op != MLOX_OTHER;
    assign lma_any = op == MLOX_LMA || op == MLOX_LMA_MOVE; // RL1 RL2
    assign mul_any = op == MLOX_MULMEM || op == MLOX_MULIMM; // RL6 RL10
    assign shadow_set = mul_any; // RL8
    // immediate multiply and no-op carry no indirect field; a direct modify never walks either
    assign aux_walk = go && indirect && in_group && op != MLOX_MULIMM && op != MLOX_NOOP; // RL3 RL4
    // both step bits together cancel, the same as neither
    assign aux_inc = instr[IND_INC] && !instr[IND_DEC]; // RL3
    assign aux_dec = instr[IND_DEC] && !instr[IND_INC]; // RL3
    assign ptr_load = !instr[IND_KEEP]; // RL3 RL5
    assign aux_cur = aux_r[aux_sel_r]; // RL14
    assign move_en = go && op == MLOX_LMA_MOVE && up_ok; // RL2
    // preload shares the clock enable so a frozen block ignores loaders too
    assign preload_en = ce && mem_wr_en;
    assign or_word = {16'h0000, word}; // RL12

    // operand address; words past the end read as zero and are never written
    always_comb begin
        if (indirect) begin
            addr = aux_r[aux_sel_r][AWIDTH-1:0]; // RL14
        end else begin
            addr = {page_r, instr[6:0]}; // RL13
        end
        addr_up = addr + 8'h01;
        addr_ok = addr <= ADDR_LAST;
        up_ok = addr_up <= ADDR_LAST && addr != 8'hff;
        word = addr_ok ? mem_r[addr] : WORD_RST;
    end

    // signed 16x16 product; operands are widened first, a 16-bit context would drop the top half
    always_comb begin
        if (op == MLOX_MULIMM) begin
            mul_b = {{(DWIDTH-IMM_W){instr[IMM_W-1]}}, instr[IMM_W-1:0]}; // RL10
        end else begin
            mul_b = word;
        end
        mcand_ext = {{(ACCW-DWIDTH){mcand_r[DWIDTH-1]}}, mcand_r};
        mulb_ext = {{(ACCW-DWIDTH){mul_b[DWIDTH-1]}}, mul_b};
        prod_raw = ACCW'($signed(mcand_ext) * $signed(mulb_ext)); // RL6 RL16
        both_min = mcand_r == MIN_WORD && mul_b == MIN_WORD;
        // the most negative square is left uncorrected at c0000000 rather than 40000000
        if (both_min) begin
            prod_nxt = MIN_SQUARE; // RL7
        end else begin
            prod_nxt = prod_raw; // RL6
        end
    end

    // accumulator
    // the add uses the product as it stood before this word, so no multiply can race it
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r <= ACC_RST;
        end else if (go) begin
            if (lma_any) begin
                acc_r <= acc_r + prod_r; // RL1 RL2 RL16
            end else if (op == MLOX_ORACC) begin
                acc_r <= acc_r | or_word; // RL12
            end
        end
    end

    // multiplicand register; accumulate above uses the old product, untouched by this load
    always_ff @(posedge clk) begin
        if (rst) begin
            mcand_r <= WORD_RST;
        end else if (go && lma_any) begin
            mcand_r <= word; // RL1 RL2
        end
    end

    // product register
    always_ff @(posedge clk) begin
        if (rst) begin
            prod_r <= PROD_RST;
        end else if (go && mul_any) begin
            prod_r <= prod_nxt; // RL6 RL10
        end
    end

    // auxiliary registers; indirect operands of any memory group member step them
    // only the entry that the pointer selects moves
    generate
        for (genvar k = 0; k < 2; k++) begin : g_aux
            always_ff @(posedge clk) begin
                if (rst) begin
                    aux_r[k] <= WORD_RST;
                end else if (aux_walk && aux_sel_r == 1'(k)) begin
                    if (aux_inc) begin
                        aux_r[k] <= aux_cur + 16'h0001; // RL3
                    end else if (aux_dec) begin
                        aux_r[k] <= aux_cur - 16'h0001; // RL3
                    end
                end
            end
        end
    endgenerate

    // pointer; a direct modify never gets here, so it stays a no-op
    // zero with no step behaves exactly like the load-pointer-immediate form
    always_ff @(posedge clk) begin
        if (rst) begin
            aux_sel_r <= 1'b0;
        end else if (aux_walk && ptr_load) begin
            aux_sel_r <= instr[IND_NEWP]; // RL3 RL4 RL5
        end
    end

    // data page bit, loaded by instructions outside this group
    always_ff @(posedge clk) begin
        if (rst) begin
            page_r <= 1'b0;
        end else if (ce && page_wr_en) begin
            page_r <= page_wr_val; // RL13
        end
    end

    // data memory; the move writes the old word one address higher
    // a move aimed past the last word is dropped rather than wrapping to word zero
    // the move wins over a preload of the same word
    generate
        for (genvar i = 0; i < MEM_WORDS; i++) begin : g_mem
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_r[i] <= WORD_RST;
                end else if (move_en && addr_up == AWIDTH'(i)) begin
                    mem_r[i] <= word; // RL2
                end else if (preload_en && mem_wr_addr == AWIDTH'(i)) begin
                    mem_r[i] <= mem_wr_data;
                end
            end
        end
    endgenerate

    // interrupt shadow: the word after a multiply always completes first
    // idle cycles keep the shadow, so a stall before the consumer still protects the product
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_block_r <= 1'b0;
        end else if (ce) begin
            if (go) begin
                irq_block_r <= shadow_set; // RL8 RL9
            end
        end
    end

    // combinational so the sequencer sees the shadow in the very cycle it matters
    assign irq_take = irq_pending && !irq_block_r && !rst; // RL8

    // completion strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= go; // RL11
        end
    end

    // read port for loaders; it never stalls execution
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_r <= WORD_RST;
        end else if (ce) begin
            if (mem_rd_addr <= ADDR_LAST) begin
                rd_r <= mem_r[mem_rd_addr];
            end else begin
                rd_r <= WORD_RST;
            end
        end
    end

    // the state view is a plain copy of the registers, nothing here is combinational
    assign instr_done = done_r;
    assign mem_rd_data = rd_r;
    assign state = '{
        acc: acc_r,
        prod: prod_r,
        mcand: mcand_r,
        aux0: aux_r[0],
        aux1: aux_r[1],
        aux_sel: aux_sel_r,
        page: page_r
    };
endmodule : mlox_exec

//--- testbench/mlox_feed.sv
// instruction fetch model that feeds one word per issue call
// assumes the caller waits for the returned edge before checking state
`timescale 1ns/1ps
module mlox_feed (
    // clock
    input wire logic clk,
    // issue
    output logic instr_valid,
    output logic [15:0] instr
);
    initial begin
        instr_valid = 1'b0;
        instr = 16'h0000;
    end
    task automatic issue(input logic [15:0] w);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        // released word is inverted so the old opcode is not left on the bus; only instr_valid low marks it idle
        instr <= ~w;
    endtask : issue
endmodule : mlox_feed

//--- testbench/mlox_props.sv
// assertions on the execution group ports
// assumes ce and instr_valid qualify every executed word
`timescale 1ns/1ps
module mlox_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // issue and view
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic page_wr_en,
    input mlox_pkg::mlox_state_t state,
    input wire logic irq_take,
    input wire logic instr_done
);
    import mlox_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic go;
    assign go = ce && instr_valid;
    sequence s_mul;
        go && (instr[15:8] == OP_MULMEM || instr[15:13] == OP_MULIMM);
    endsequence
    sequence s_lma;
        go && (instr[15:8] == OP_LMA || instr[15:8] == OP_LMA_MOVE);
    endsequence
    a_done_pulse: assert property (go |=> instr_done) else $error("done missing");
    a_idle_done: assert property (ce && !instr_valid |=> !instr_done) else $error("stray done");
    a_mul_shadow: assert property (s_mul |=> !irq_take) else $error("irq after multiply");
    a_noop_stable: assert property (go && instr == OP_NOOP && !page_wr_en |=> $stable(state))
        else $error("noop changed state");
    a_direct_modaux: assert property (go && instr[15:7] == {OP_MODAUX, 1'b0} && !page_wr_en |=> $stable(state))
        else $error("direct modify changed state");
    a_modaux_only: assert property (go && instr[15:7] == {OP_MODAUX, 1'b1}
        |=> $stable({state.acc, state.prod, state.mcand})) else $error("modify touched data");
    a_or_high: assert property (go && instr[15:8] == OP_ORACC |=> $stable(state.acc[31:16]))
        else $error("or changed high half");
    a_lma_sum: assert property (s_lma |=> state.acc == $past(state.acc) + $past(state.prod))
        else $error("accumulate wrong");
    a_imm_prod: assert property (go && instr[15:13] == OP_MULIMM |=> state.prod ==
        32'($signed($past(state.mcand))) * 32'($signed($past(instr[12:0])))) else $error("imm product");
endmodule : mlox_props
bind mlox_exec mlox_props u_props (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .page_wr_en(page_wr_en), .state(state), .irq_take(irq_take), .instr_done(instr_done));

//--- testbench/testbench.sv
// self-checking bench for the execution group
// assumes the feed model drives instructions and memory is preloaded here
`timescale 1ns/1ps
module testbench;
    import mlox_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic irq_pending = 1'b0;
    logic mem_wr_en = 1'b0;
    logic page_wr_en = 1'b0;
    logic page_wr_val = 1'b0;
    logic [7:0] mem_wr_addr = 8'h00;
    logic [7:0] mem_rd_addr = 8'h00;
    logic [15:0] mem_wr_data = 16'h0000;
    logic [15:0] mem_rd_data, instr, v;
    logic instr_valid, irq_take, instr_done;
    mlox_state_t state;
    int n_errors = 0;
    int checked = 0;
    always #2 clk = ~clk;
    mlox_feed feed (.clk(clk), .instr_valid(instr_valid), .instr(instr));
    mlox_exec dut (.clk(clk), .rst(rst), .ce(1'b1), .instr_valid(instr_valid), .instr(instr),
        .irq_pending(irq_pending), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .page_wr_en(page_wr_en), .page_wr_val(page_wr_val), .state(state), .irq_take(irq_take),
        .instr_done(instr_done), .mem_rd_data(mem_rd_data), .mem_rd_addr(mem_rd_addr));
    task automatic give_verdict;
        if (n_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        mem_wr_en <= 1'b1;
        mem_wr_addr <= a;
        mem_wr_data <= d;
        @(posedge clk);
        mem_wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        mem_rd_addr <= a;
        @(posedge clk);
        #1 v = mem_rd_data;
    endtask : rd
    task automatic run(input logic [15:0] w);
        feed.issue(w);
        #1;
    endtask : run
    task automatic t_mul;
        wr(8'h05, 16'h8000);
        wr(8'h06, 16'h0003);
        run(16'h6c05);
        chk(state.mcand, 32'h0000_8000);
        @(posedge clk) irq_pending <= 1'b1;
        run(16'h6d05);
        chk(state.prod, 32'hc000_0000);
        chk(irq_take, 32'h0);
        run(16'h6c06);
        chk(irq_take, 32'h1);
        chk(state.acc, 32'hc000_0000);
        @(posedge clk) irq_pending <= 1'b0;
        run(16'h9ff7);
        chk(state.prod, 32'hffff_ffe5);
    endtask : t_mul
    task automatic t_move_or;
        run(16'h6b06);
        chk(state.acc, 32'hbfff_ffe5);
        rd(8'h07);
        chk(v, 32'h0000_0003);
        wr(8'h08, 16'h0a0a);
        run(16'h7a08);
        chk(state.acc, 32'hbfff_ffef);
    endtask : t_move_or
    task automatic t_aux;
        run(16'h68a1);
        chk({state.aux0, 15'h0, state.aux_sel}, 32'h0001_0001);
        run(16'h6898);
        chk(state.aux1, 32'h0000_ffff);
        run(16'h6880);
        chk(state.aux_sel, 32'h0);
        run(16'h6805);
        run(16'h7f80);
        chk(state.acc, 32'hbfff_ffef);
        chk(state.aux0, 32'h0000_0001);
    endtask : t_aux
    task automatic t_page;
        wr(8'h85, 16'h1234);
        wr(8'h01, 16'h00aa);
        @(posedge clk) page_wr_en <= 1'b1;
        page_wr_val <= 1'b1;
        @(posedge clk) page_wr_en <= 1'b0;
        run(16'h6c05);
        chk(state.mcand, 32'h0000_1234);
        run(16'h6c88);
        chk(state.mcand, 32'h0000_00aa);
    endtask : t_page
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1 chk(state.acc | state.prod, 32'h0);
        t_mul();
        t_move_or();
        t_aux();
        t_page();
        give_verdict();
    end
    initial begin
        // whole run is under 200 cycles
        #4000;
        n_errors++;
        give_verdict();
    end
endmodule : testbench
